// ==== logic/dmb_pkg.sv ====
package dmb_pkg;

  // ----------------------------------------------------------------
  // Address space geometry
  // ----------------------------------------------------------------
  localparam int DMB_ADDR_W = 12;
  localparam int DMB_OFS_W = 8;
  localparam int DMB_BANK_W = 4;
  localparam int DMB_DATA_W = 8;
  localparam int DMB_RAM_AW = 11;
  localparam int DMB_RAM_DEPTH = 2048;

  // Banks below this number hold real storage; the rest read as zero, except the bank pointer location.
  localparam logic [3:0] DMB_IMPL_BANKS = 4'h8;
  // Bank that carries the special function registers.
  localparam logic [3:0] DMB_SFR_BANK = 4'hF;
  // Fast-access offsets below this value map to bank 0, the rest to the SPECIAL_FUNCTION_REGS bank.
  localparam logic [7:0] DMB_ACCESS_SPLIT = 8'h60;
  // Location of the bank pointer inside the SPECIAL_FUNCTION_REGS bank.
  localparam logic [11:0] DMB_BP_ADDR = 12'hFE0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] DMB_BP_RESET = 4'h0;
  localparam logic [7:0] DMB_DATA_RESET = 8'h00;
  localparam logic [11:0] DMB_ADDR_RESET = 12'h000;

  // Addressing mode chosen by the instruction, Gray coded.
  typedef enum logic [1:0] {
    DMB_MODE_BANKED = 2'b00,
    DMB_MODE_ACCESS = 2'b01,
    DMB_MODE_FULL = 2'b11
  } dmb_mode_t;

  // Where a pending access lands.
  typedef enum logic [1:0] {
    DMB_TGT_NONE = 2'b00,
    DMB_TGT_RAM = 2'b01,
    DMB_TGT_BP = 2'b11
  } dmb_tgt_t;

endpackage

// ==== logic/dmb_ram.sv ====
`timescale 1ns/100ps
`default_nettype none

module dmb_ram
  import dmb_pkg::*;
(
  input wire logic clk, // Core clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic we, // Write strobe.
  input wire logic [DMB_RAM_AW-1:0] addr, // Word address.
  input wire logic [DMB_DATA_W-1:0] wdata, // Write data.
  output logic [DMB_DATA_W-1:0] rdata // Registered read data.
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [DMB_DATA_W-1:0] mem [DMB_RAM_DEPTH];

  // Storage itself has no reset, so it maps onto plain block RAM.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // Read data leaves through a register; a write returns the old value.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= DMB_DATA_RESET;
    end else begin
      rdata <= mem[addr];
    end
  end

endmodule

`default_nettype wire

// ==== logic/dmb_core.sv ====
// Operation
// - Decode full 12-bit address, 4096 bytes.
// - Sixteen banks; upper nibble selects bank.
// - Unimplemented locations read as zero.
// - 256-byte fast window ignores bank pointer.
// - Address from full operand or bank+offset.
// - Bank pointer gives top four bits.
// - Bank pointer upper nibble reads zero.
// - Load-bank-literal loads bank pointer directly.
// - Unimplemented banks: writes dropped, reads zero; the bank pointer at FE0 in bank F still takes writes and reads.
// - Status flags update as if access succeeded.
// - Full-address move ignores bank pointer.
// - Other instructions use pointer or window.
`timescale 1ns/100ps
`default_nettype none

module dmb_core
  import dmb_pkg::*;
(
  input wire logic clk, // Core clock, 100 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic req_valid, // Data access request, one cycle.
  input wire logic req_write, // High for write, low for read.
  input wire dmb_mode_t req_mode, // Addressing mode of the instruction.
  input wire logic [DMB_ADDR_W-1:0] full_addr, // Full operand address.
  input wire logic [DMB_OFS_W-1:0] offset, // In-bank offset from the opcode.
  input wire logic [DMB_DATA_W-1:0] wdata, // Write data.
  input wire logic lbl_valid, // Load-bank-literal strobe.
  input wire logic [DMB_DATA_W-1:0] lbl_value, // Literal for the bank pointer.
  output logic rsp_valid, // Access finished, one-cycle pulse.
  output logic [DMB_DATA_W-1:0] rdata, // Read data, zero after a write.
  output logic zero_flag, // Zero flag for the status register.
  output logic [DMB_DATA_W-1:0] bank_pointer, // Bank pointer, upper nibble zero.
  output logic [DMB_ADDR_W-1:0] eff_addr, // Last decoded address.
  output logic unmapped // Last access hit no storage.
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DMB_BANK_W-1:0] bp;
    logic p_valid;
    logic p_write;
    dmb_tgt_t p_tgt;
    logic [DMB_DATA_W-1:0] p_data;
    logic rsp_valid;
    logic [DMB_DATA_W-1:0] rdata;
    logic zero_flag;
    logic [DMB_ADDR_W-1:0] eff_addr;
    logic unmapped;
  } dmb_state_t;

  dmb_state_t s;
  dmb_state_t next_s;
  logic [DMB_ADDR_W-1:0] addr;
  logic [DMB_BANK_W-1:0] bank;
  logic ram_hit;
  logic bp_hit;
  logic ram_we;
  logic [DMB_DATA_W-1:0] ram_q;
  logic [DMB_DATA_W-1:0] value;

  // ----------------------------------------------------------------
  // Address formation
  // ----------------------------------------------------------------
  // The mode picks the address source before any bank decode.
  always_comb begin
    case (req_mode)
      DMB_MODE_FULL: begin
        addr = full_addr;
      end
      DMB_MODE_ACCESS: begin
        // The window never consults the bank pointer.
        if (offset < DMB_ACCESS_SPLIT) begin
          addr = {4'h0, offset};
        end else begin
          addr = {DMB_SFR_BANK, offset};
        end
      end
      default: begin
        addr = {s.bp, offset};
      end
    endcase
  end

  // Upper nibble is the bank, lower byte the location within it.
  assign bank = addr[DMB_ADDR_W-1:DMB_OFS_W];
  assign ram_hit = bank < DMB_IMPL_BANKS;
  assign bp_hit = addr == DMB_BP_ADDR;
  // Writes to banks without storage are simply not passed on.
  assign ram_we = req_valid & req_write & ram_hit;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  dmb_ram u_ram (
    .clk(clk),
    .rst(rst),
    .we(ram_we),
    .addr(addr[DMB_RAM_AW-1:0]),
    .wdata(wdata),
    .rdata(ram_q)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Two-stage flow: the request edge starts the RAM read, the next edge
  // captures the answer, so rsp_valid comes two edges after req_valid.
  always_comb begin
    next_s = s;
    value = DMB_DATA_RESET;
    next_s.p_valid = req_valid;
    next_s.p_write = req_write;
    next_s.p_data = wdata;
    next_s.p_tgt = DMB_TGT_NONE;
    if (req_valid) begin
      next_s.eff_addr = addr;
      next_s.unmapped = !ram_hit && !bp_hit;
      if (ram_hit) begin
        next_s.p_tgt = DMB_TGT_RAM;
      end else if (bp_hit) begin
        next_s.p_tgt = DMB_TGT_BP;
        if (!req_write) begin
          next_s.p_data = {4'h0, s.bp};
        end
      end
      // Only the low nibble is stored; upper write bits vanish.
      if (req_write && bp_hit) begin
        next_s.bp = wdata[DMB_BANK_W-1:0];
      end
    end
    // The literal load wins over a same-cycle data write to the pointer.
    if (lbl_valid) begin
      next_s.bp = lbl_value[DMB_BANK_W-1:0];
    end
    // Answer stage; a miss reads zero but still yields a flag.
    next_s.rsp_valid = s.p_valid;
    if (s.p_valid) begin
      if (s.p_write) begin
        value = s.p_data;
        next_s.rdata = DMB_DATA_RESET;
      end else begin
        case (s.p_tgt)
          DMB_TGT_RAM: value = ram_q;
          DMB_TGT_BP: value = s.p_data;
          default: value = DMB_DATA_RESET;
        endcase
        next_s.rdata = value;
      end
      next_s.zero_flag = value == DMB_DATA_RESET;
    end
  end

  // ----------------------------------------------------------------
  // Registers and outputs
  // ----------------------------------------------------------------
  // All state apart from the RAM in u_ram lives in one struct register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.bp <= DMB_BP_RESET;
      s.eff_addr <= DMB_ADDR_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign rsp_valid = s.rsp_valid;
  assign rdata = s.rdata;
  assign zero_flag = s.zero_flag;
  assign bank_pointer = {4'h0, s.bp};
  assign eff_addr = s.eff_addr;
  assign unmapped = s.unmapped;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  bp_upper_a: assert property (bank_pointer[7:4] == 4'h0)
    else $error("Bank pointer upper nibble not zero.");

  lbl_load_a: assert property (lbl_valid |=> bank_pointer[3:0] == $past(lbl_value[3:0]))
    else $error("Literal load did not reach the bank pointer.");

  banked_addr_a: assert property (req_valid && req_mode == DMB_MODE_BANKED
    |=> eff_addr == {$past(s.bp), $past(offset)})
    else $error("Banked address not formed from pointer and offset.");

  full_addr_a: assert property (req_valid && req_mode == DMB_MODE_FULL
    |=> eff_addr == $past(full_addr))
    else $error("Full address move did not use its operand.");

  access_low_a: assert property (req_valid && req_mode == DMB_MODE_ACCESS
    && offset < DMB_ACCESS_SPLIT |=> eff_addr[11:8] == 4'h0)
    else $error("Low window half not mapped to bank 0.");

  access_high_a: assert property (req_valid && req_mode == DMB_MODE_ACCESS
    && offset >= DMB_ACCESS_SPLIT |=> eff_addr[11:8] == DMB_SFR_BANK)
    else $error("High window half not mapped to the SPECIAL_FUNCTION_REGS bank.");

  miss_write_a: assert property (req_valid && req_write && bank >= DMB_IMPL_BANKS
    |-> !ram_we)
    else $error("Write to an unimplemented bank reached storage.");

  miss_read_a: assert property (req_valid && !req_write && bank >= DMB_IMPL_BANKS
    && !bp_hit |-> ##2 rsp_valid && rdata == 8'h00 && zero_flag)
    else $error("Unimplemented read did not answer zero with flag.");

  rsp_lat_a: assert property (req_valid |-> ##2 rsp_valid)
    else $error("Access did not answer two cycles later.");

  // A write sets the zero flag from its data, even when the bank has no storage.
  write_flag_a: assert property (req_valid && req_write
    |-> ##2 zero_flag == ($past(wdata, 2) == DMB_DATA_RESET))
    else $error("Write did not update the zero flag from its data.");

endmodule

`default_nettype wire

// ==== test/dmb_cpu_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module dmb_cpu_model
  import dmb_pkg::*;
(
  input wire logic clk, // Core clock.
  output logic req_valid, // Access request.
  output logic req_write, // High for a write.
  output dmb_mode_t req_mode, // Addressing mode.
  output logic [DMB_ADDR_W-1:0] full_addr, // Full operand address.
  output logic [DMB_OFS_W-1:0] offset, // In-bank offset.
  output logic [DMB_DATA_W-1:0] wdata, // Write data.
  output logic lbl_valid, // Literal load strobe.
  output logic [DMB_DATA_W-1:0] lbl_value, // Literal value.
  input wire logic rsp_valid, // Access finished.
  input wire logic [DMB_DATA_W-1:0] rdata // Read data.
);
  // Quiet bus at time zero.
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_mode = DMB_MODE_BANKED;
    full_addr = 12'h000;
    offset = 8'h00;
    wdata = 8'h00;
    lbl_valid = 1'b0;
    lbl_value = 8'h00;
  end

  // One access; operands are inverted once released so stale values cannot help.
  task automatic access(input logic wr, input dmb_mode_t m, input logic [11:0] fa,
                        input logic [7:0] ofs, input logic [7:0] wd,
                        output logic [7:0] rd, output logic ok);
    ok = 1'b0;
    rd = 8'h00;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_mode <= m;
    full_addr <= fa;
    offset <= ofs;
    wdata <= wd;
    @(posedge clk);
    req_valid <= 1'b0;
    full_addr <= ~fa;
    offset <= ~ofs;
    wdata <= ~wd;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk);
      #1;
      if (rsp_valid === 1'b1) begin
        ok = 1'b1;
        rd = rdata;
      end
    end
  endtask

  // Bank selection always precedes the banked accesses that rely on it.
  task automatic load_bank(input logic [7:0] v);
    @(posedge clk);
    lbl_valid <= 1'b1;
    lbl_value <= v;
    @(posedge clk);
    lbl_valid <= 1'b0;
    lbl_value <= ~v;
    #1;
  endtask
endmodule

`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import dmb_pkg::*;
;
  logic clk, rst, req_valid, req_write, lbl_valid, rsp_valid, zero_flag, unmapped, ok;
  dmb_mode_t req_mode;
  logic [11:0] full_addr, eff_addr;
  logic [7:0] offset, wdata, lbl_value, rdata, bank_pointer, rd;
  int num_errors = 0;
  int n_tests = 0;

  dmb_core dmb_core_inst(.clk(clk), .rst(rst), .req_valid(req_valid),
    .req_write(req_write), .req_mode(req_mode), .full_addr(full_addr), .offset(offset),
    .wdata(wdata), .lbl_valid(lbl_valid), .lbl_value(lbl_value), .rsp_valid(rsp_valid),
    .rdata(rdata), .zero_flag(zero_flag), .bank_pointer(bank_pointer),
    .eff_addr(eff_addr), .unmapped(unmapped));
  dmb_cpu_model dmb_cpu_model_inst(.clk(clk), .req_valid(req_valid),
    .req_write(req_write), .req_mode(req_mode), .full_addr(full_addr), .offset(offset),
    .wdata(wdata), .lbl_valid(lbl_valid), .lbl_value(lbl_value), .rsp_valid(rsp_valid),
    .rdata(rdata));

  // Free-running 100 MHz core clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // A missing response ends the run at once, since later checks would cascade.
  task automatic acc(input logic wr, input dmb_mode_t m, input logic [11:0] fa,
                     input logic [7:0] ofs, input logic [7:0] wd);
    dmb_cpu_model_inst.access(wr, m, fa, ofs, wd, rd, ok);
    if (!ok) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      conclude();
    end
  endtask

  task automatic t_literal;
    chk(bank_pointer, 12'h000);
    dmb_cpu_model_inst.load_bank(8'hA3);
    chk(bank_pointer, 12'h003);
    $display("literal load done");
  endtask

  task automatic t_banked;
    acc(1'b1, DMB_MODE_BANKED, 12'hABC, 8'h45, 8'h5A);
    chk(eff_addr, 12'h345);
    acc(1'b1, DMB_MODE_FULL, 12'h7FF, 8'h45, 8'hC3);
    chk(eff_addr, 12'h7FF);
    acc(1'b0, DMB_MODE_FULL, 12'h345, 8'h00, 8'h00);
    chk(rd, 12'h05A);
    dmb_cpu_model_inst.load_bank(8'h07);
    acc(1'b0, DMB_MODE_BANKED, 12'h000, 8'hFF, 8'h00);
    chk(rd, 12'h0C3);
    acc(1'b0, dmb_mode_t'(2'b10), 12'h000, 8'hFF, 8'h00);
    chk(rd, 12'h0C3);
    $display("banked and full addressing done");
  endtask

  task automatic t_unimpl;
    acc(1'b1, DMB_MODE_FULL, 12'h110, 8'h00, 8'h11);
    dmb_cpu_model_inst.load_bank(8'h09);
    acc(1'b1, DMB_MODE_BANKED, 12'h000, 8'h10, 8'h77);
    chk(zero_flag, 12'h000);
    chk(unmapped, 12'h001);
    acc(1'b0, DMB_MODE_BANKED, 12'h000, 8'h10, 8'h00);
    chk(rd, 12'h000);
    chk(zero_flag, 12'h001);
    acc(1'b0, DMB_MODE_FULL, 12'h110, 8'h00, 8'h00);
    chk(rd, 12'h011);
    $display("unimplemented bank done");
  endtask

  task automatic t_window;
    acc(1'b1, DMB_MODE_ACCESS, 12'h000, 8'h5F, 8'h21);
    chk(eff_addr, 12'h05F);
    acc(1'b0, DMB_MODE_FULL, 12'h05F, 8'h00, 8'h00);
    chk(rd, 12'h021);
    acc(1'b0, DMB_MODE_ACCESS, 12'h000, 8'h60, 8'h00);
    chk(eff_addr, 12'hF60);
    chk(rd, 12'h000);
    acc(1'b0, DMB_MODE_ACCESS, 12'h000, 8'hE0, 8'h00);
    chk(rd, 12'h009);
    chk(unmapped, 12'h000);
    $display("fast-access window done");
  endtask

  // Reset for eight cycles, then the scenarios in turn.
  initial begin
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_literal();
    t_banked();
    t_unimpl();
    t_window();
    conclude();
  end
endmodule

`default_nettype wire
